// ---- fgt_defines.vh ----
/*
 fine-grained trap constants: sysreg encodings, field positions, syndrome codes.
 assumes inclusion by bare name from the design files.
*/
`ifndef FGT_DEFINES_VH
`define FGT_DEFINES_VH
`define EL0 2'h0
`define EL1 2'h1
`define EL2 2'h2
`define EL3 2'h3
`define ENC_OP0 2'h3
`define ENC_OP1 3'h4
`define ENC_CRN 4'h1
`define ENC_CRM 4'h1
`define ENC_OP2_RD 3'h4
`define ENC_OP2_WR 3'h5
`define EC_SYSREG 6'h18
`define NV_PAGE_RD_OFFSET 12'h1B8
`define NV_PAGE_WR_OFFSET 12'h1C0
`define RT_AUXF_BIT 0
`define WT_TID2_BIT 55
`define WT_SPRI_BIT 54
`define WT_ACCD_BIT 50
`define WT_EADDR_BIT 49
`define WT_FICNT_BIT 48
`define WT_FICTL_BIT 47
`define WT_EMISC_BIT 45
`define WT_ESTAT_BIT 44
`define WT_UPPER_LSB 44
`define REG_RESET 64'h0000_0000_0000_0000
`define TGT_NONE 3'h0
`define TGT_AUXF 3'h1
`define TGT_TID2 3'h2
`define TGT_SPRI 3'h3
`define TGT_ACCD 3'h4
`define TGT_EADDR 3'h5
`define TGT_FICNT 3'h6
`define TGT_FICTL 3'h7
`endif

// ---- fgt_sysreg_access.v ----
/*
 access-control decision for a hypervisor fine-grained trap control register.
 assumes el and debug state come from logic on sys_clk.
*/
`default_nettype none
`include "fgt_defines.vh"
module fgt_sysreg_access (
    // state
    input  wire [1:0] cur_el,
    input  wire       hyp_enabled,
    input  wire       monitor_present,
    input  wire       monitor_fine_trap_enable,
    input  wire       nested_virt_enable,
    input  wire       nested_virt_memory_redirect,
    input  wire       halted,
    input  wire       secure_debug_disabled,
    input  wire       sdd_undef_first,
    input  wire       reg_present,
    // decision
    output reg        acc_undef,
    output reg        acc_trap_hyp,
    output reg        acc_trap_mon,
    output reg        acc_redirect,
    output reg        acc_direct
);
    wire mon_block;
    assign mon_block = monitor_present & ~monitor_fine_trap_enable;
    always @*
    begin
        acc_undef    = 1'b0;
        acc_trap_hyp = 1'b0;
        acc_trap_mon = 1'b0;
        acc_redirect = 1'b0;
        acc_direct   = 1'b0;
        if (!reg_present)
            acc_undef = 1'b1;
        else
            case (cur_el)
                `EL0: acc_undef = 1'b1;
                `EL1:
                    if (hyp_enabled & nested_virt_enable & nested_virt_memory_redirect)
                        acc_redirect = 1'b1;
                    else if (hyp_enabled & nested_virt_enable)
                        acc_trap_hyp = 1'b1;
                    else
                        acc_undef = 1'b1;
                `EL2:
                    if (halted & secure_debug_disabled & sdd_undef_first & mon_block)
                        acc_undef = 1'b1;
                    else if (mon_block)
                    begin
                        if (halted & secure_debug_disabled)
                            acc_undef = 1'b1;
                        else
                            acc_trap_mon = 1'b1;
                    end
                    else
                        acc_direct = 1'b1;
                default: acc_direct = 1'b1;
            endcase
    end
endmodule
`default_nettype wire

// ---- fgt_write_mask.v ----
/*
 write-trap writable-bit mask built from the implemented features.
 assumes feature straps are constant while out of reset.
*/
`default_nettype none
`include "fgt_defines.vh"
module fgt_write_mask (
    // features
    input  wire        feat_mtx,
    input  wire        feat_accdata,
    input  wire        feat_ras,
    input  wire        feat_rasv1p1,
    input  wire        ras_records_absent,
    // mask
    output wire [63:0] wmask
);
    wire ras_on;
    wire ras11_on;
    // error-record fields may be reserved-zero when no records exist
    assign ras_on   = feat_ras & ~ras_records_absent;
    assign ras11_on = feat_rasv1p1 & ras_on;
    genvar i;
    generate
        for (i = 0; i < 64; i = i + 1)
        begin : g_mask
            if (i == `WT_TID2_BIT || i == `WT_SPRI_BIT)
            begin : g_mtx
                assign wmask[i] = feat_mtx;
            end
            else if (i == `WT_ACCD_BIT)
            begin : g_acc
                assign wmask[i] = feat_accdata;
            end
            else if (i == `WT_EADDR_BIT || i == `WT_EMISC_BIT || i == `WT_ESTAT_BIT)
            begin : g_ras
                assign wmask[i] = ras_on;
            end
            else if (i == `WT_FICNT_BIT || i == `WT_FICTL_BIT)
            begin : g_ras11
                assign wmask[i] = ras11_on;
            end
            else if (i < `WT_UPPER_LSB)
            begin : g_low
                assign wmask[i] = 1'b1;
            end
            else
            begin : g_res0
                assign wmask[i] = 1'b0;
            end
        end
    endgenerate
endmodule
`default_nettype wire

// ---- fine_grained_sysreg_trap_control.v ----
/*
 holds both trap control registers, decodes their accesses, decides guest traps.
 assumes one sysreg access per cycle, inputs synchronous to sys_clk, rst_b warm reset.
*/
// Contract
// - read-trap bit 0 traps kernel reads of aux fault status zero, class 0x18.
// - warm reset clears every non error-record trap field to zero.
// - read-trap register encoded op0 3, op1 4, CRn 1, CRm 1, op2 4.
// - user-level access to the read-trap register is undefined.
// - kernel access with both nested-virt bits set goes to page offset 0x1B8.
// - kernel with only nested-virt enable traps to hypervisor; else undefined.
// - hypervisor access with monitor enable 0 traps to monitor, or undefined halted.
// - implementation option puts the halted undefined ahead of the monitor trap.
// - monitor level, or untrapped hypervisor level, reads and writes all 64 bits.
// - write-trap register exists only with the feature; otherwise undefined.
// - bit 55 zero traps kernel and user second thread id writes.
// - bit 54 zero traps kernel streaming priority writes.
// - bit 50 zero traps kernel accelerator data writes.
// - bits 44 and 49 trap error record status and address writes.
// - bits 48 and 47 trap fault-injection countdown and control writes.
// - bit 45 traps writes of the four misc error-record registers.
// - error-record fields may be reserved-zero when no records exist.
// - error-record fields reset to zero when the monitor level is absent.
// - fields of absent optional features behave as reserved-zero.
// - a fine-grained trap yields to any higher-priority exception.
`default_nettype none
`include "fgt_defines.vh"
module fine_grained_sysreg_trap_control (
    // clock and warm reset
    input  wire        sys_clk,
    input  wire        rst_b,
    // configuration straps
    input  wire        fine_grained_trap_feature,
    input  wire        feat_mtx,
    input  wire        feat_accdata,
    input  wire        feat_ras,
    input  wire        feat_rasv1p1,
    input  wire        ras_records_absent,
    input  wire        monitor_present,
    input  wire        sdd_undef_first,
    // processor state
    input  wire [1:0]  cur_el,
    input  wire        hyp_enabled,
    input  wire        monitor_fine_trap_enable,
    input  wire        nested_virt_enable,
    input  wire        nested_virt_memory_redirect,
    input  wire        host_kernel_at_hyp,
    input  wire        trap_general_to_hyp,
    input  wire        halted,
    input  wire        secure_debug_disabled,
    // access to the trap control registers
    input  wire        acc_valid,
    input  wire        acc_write,
    input  wire [1:0]  acc_op0,
    input  wire [2:0]  acc_op1,
    input  wire [3:0]  acc_crn,
    input  wire [3:0]  acc_crm,
    input  wire [2:0]  acc_op2,
    input  wire [63:0] acc_wdata,
    output reg  [63:0] acc_rdata,
    output reg         acc_done,
    output reg         acc_undef,
    output reg         acc_trap_hyp,
    output reg         acc_trap_mon,
    output reg         acc_redirect,
    output reg  [11:0] acc_redirect_offset,
    // guest access to be checked against fine traps
    input  wire        chk_valid,
    input  wire        chk_write,
    input  wire [2:0]  chk_target,
    input  wire        chk_higher_exc,
    output reg         chk_trap,
    output reg  [5:0]  chk_syndrome,
    // register contents
    output wire [63:0] read_trap_value,
    output wire [63:0] write_trap_value
);
    reg  [63:0] hyp_fine_read_trap_ctrl_reg;
    reg  [63:0] hyp_fine_write_trap_ctrl_reg;
    reg  [63:0] hyp_fine_read_trap_ctrl_next;
    reg  [63:0] hyp_fine_write_trap_ctrl_next;
    wire [63:0] wmask;
    wire        sel_rd;
    wire        sel_wr;
    wire        dec_hit;
    wire        rd_undef;
    wire        rd_trap_hyp;
    wire        rd_trap_mon;
    wire        rd_redirect;
    wire        rd_direct;
    wire        wr_undef;
    wire        wr_trap_hyp;
    wire        wr_trap_mon;
    wire        wr_redirect;
    wire        wr_direct;
    wire        sel_undef;
    wire        sel_direct;
    wire        fine_ok;
    wire        host_mode;
    wire        kernel;
    wire        user;
    wire [63:0] wt;
    reg         fire;

    assign sel_rd = (acc_op0 == `ENC_OP0) && (acc_op1 == `ENC_OP1) && (acc_crn == `ENC_CRN)
                    && (acc_crm == `ENC_CRM) && (acc_op2 == `ENC_OP2_RD);
    assign sel_wr = (acc_op0 == `ENC_OP0) && (acc_op1 == `ENC_OP1) && (acc_crn == `ENC_CRN)
                    && (acc_crm == `ENC_CRM) && (acc_op2 == `ENC_OP2_WR);
    assign dec_hit = acc_valid & (sel_rd | sel_wr);

    fgt_write_mask u_mask (
        .feat_mtx           (feat_mtx),
        .feat_accdata       (feat_accdata),
        .feat_ras           (feat_ras),
        .feat_rasv1p1       (feat_rasv1p1),
        .ras_records_absent (ras_records_absent),
        .wmask              (wmask)
    );

    fgt_sysreg_access u_rd_access (
        .cur_el                      (cur_el),
        .hyp_enabled                 (hyp_enabled),
        .monitor_present             (monitor_present),
        .monitor_fine_trap_enable    (monitor_fine_trap_enable),
        .nested_virt_enable          (nested_virt_enable),
        .nested_virt_memory_redirect (nested_virt_memory_redirect),
        .halted                      (halted),
        .secure_debug_disabled       (secure_debug_disabled),
        .sdd_undef_first             (sdd_undef_first),
        .reg_present                 (1'b1),
        .acc_undef                   (rd_undef),
        .acc_trap_hyp                (rd_trap_hyp),
        .acc_trap_mon                (rd_trap_mon),
        .acc_redirect                (rd_redirect),
        .acc_direct                  (rd_direct)
    );

    fgt_sysreg_access u_wr_access (
        .cur_el                      (cur_el),
        .hyp_enabled                 (hyp_enabled),
        .monitor_present             (monitor_present),
        .monitor_fine_trap_enable    (monitor_fine_trap_enable),
        .nested_virt_enable          (nested_virt_enable),
        .nested_virt_memory_redirect (nested_virt_memory_redirect),
        .halted                      (halted),
        .secure_debug_disabled       (secure_debug_disabled),
        .sdd_undef_first             (sdd_undef_first),
        .reg_present                 (fine_grained_trap_feature),
        .acc_undef                   (wr_undef),
        .acc_trap_hyp                (wr_trap_hyp),
        .acc_trap_mon                (wr_trap_mon),
        .acc_redirect                (wr_redirect),
        .acc_direct                  (wr_direct)
    );

    assign sel_undef  = sel_rd ? rd_undef : wr_undef;
    assign sel_direct = sel_rd ? rd_direct : wr_direct;

    // register update: full 64 bits for read-trap, masked for write-trap
    always @*
    begin
        hyp_fine_read_trap_ctrl_next  = hyp_fine_read_trap_ctrl_reg;
        hyp_fine_write_trap_ctrl_next = hyp_fine_write_trap_ctrl_reg & wmask;
        if (dec_hit && acc_write && sel_direct)
        begin
            if (sel_rd)
                hyp_fine_read_trap_ctrl_next = acc_wdata;
            else
                hyp_fine_write_trap_ctrl_next = acc_wdata & wmask;
        end
    end

    // error-record fields zero even with a monitor level: any value is legal there
    always @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            hyp_fine_read_trap_ctrl_reg  <= `REG_RESET;
            hyp_fine_write_trap_ctrl_reg <= `REG_RESET;
        end
        else
        begin
            hyp_fine_read_trap_ctrl_reg  <= hyp_fine_read_trap_ctrl_next;
            hyp_fine_write_trap_ctrl_reg <= hyp_fine_write_trap_ctrl_next;
        end
    end

    assign read_trap_value  = hyp_fine_read_trap_ctrl_reg;
    assign write_trap_value = hyp_fine_write_trap_ctrl_reg;

    // access response one cycle after the request
    always @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            acc_rdata           <= `REG_RESET;
            acc_done            <= 1'b0;
            acc_undef           <= 1'b0;
            acc_trap_hyp        <= 1'b0;
            acc_trap_mon        <= 1'b0;
            acc_redirect        <= 1'b0;
            acc_redirect_offset <= 12'h000;
        end
        else
        begin
            acc_done     <= dec_hit;
            acc_undef    <= dec_hit & sel_undef;
            acc_trap_hyp <= dec_hit & (sel_rd ? rd_trap_hyp : wr_trap_hyp);
            acc_trap_mon <= dec_hit & (sel_rd ? rd_trap_mon : wr_trap_mon);
            acc_redirect <= dec_hit & (sel_rd ? rd_redirect : wr_redirect);
            acc_redirect_offset <= sel_rd ? `NV_PAGE_RD_OFFSET : `NV_PAGE_WR_OFFSET;
            if (dec_hit && !acc_write && sel_direct)
                acc_rdata <= sel_rd ? hyp_fine_read_trap_ctrl_reg
                                    : hyp_fine_write_trap_ctrl_reg;
            else
                acc_rdata <= `REG_RESET;
        end
    end

    // guest access trap check
    assign fine_ok   = hyp_enabled & (~monitor_present | monitor_fine_trap_enable);
    assign host_mode = host_kernel_at_hyp & trap_general_to_hyp;
    assign kernel    = (cur_el == `EL1);
    assign user      = (cur_el == `EL0);
    assign wt        = write_trap_value;

    always @*
    begin
        fire = 1'b0;
        if (!chk_write)
            fire = kernel && (chk_target == `TGT_AUXF)
                   && hyp_fine_read_trap_ctrl_reg[`RT_AUXF_BIT];
        else if (fine_grained_trap_feature)
            case (chk_target)
                `TGT_TID2:  fire = feat_mtx && !wt[`WT_TID2_BIT] && !host_mode
                                   && (kernel || user);
                `TGT_SPRI:  fire = kernel && feat_mtx && !wt[`WT_SPRI_BIT];
                `TGT_ACCD:  fire = kernel && feat_accdata && !wt[`WT_ACCD_BIT];
                `TGT_EADDR: fire = kernel && wt[`WT_EADDR_BIT];
                `TGT_FICNT: fire = kernel && wt[`WT_FICNT_BIT];
                `TGT_FICTL: fire = kernel && wt[`WT_FICTL_BIT];
                `TGT_AUXF:  fire = kernel && wt[`WT_ESTAT_BIT];
                `TGT_NONE:  fire = kernel && wt[`WT_EMISC_BIT];
                default:      fire = 1'b0;
            endcase
    end

    always @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            chk_trap     <= 1'b0;
            chk_syndrome <= 6'h00;
        end
        else
        begin
            chk_trap     <= chk_valid & fire & fine_ok & ~chk_higher_exc;
            chk_syndrome <= (chk_valid & fire & fine_ok & ~chk_higher_exc) ? `EC_SYSREG : 6'h00;
        end
    end
endmodule
`default_nettype wire

// ---- fine_grained_sysreg_trap_control_assertions.sv ----
/* concurrent checks bound to the trap control top.
   assumes one clock, sys_clk, and async warm reset rst_b. */
`default_nettype none
`include "fgt_defines.vh"
module fgt_trap_checker (
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        rst_b,
    // straps and state
    input wire logic        fine_grained_trap_feature,
    input wire logic        monitor_present,
    input wire logic [1:0]  cur_el,
    input wire logic        hyp_enabled,
    input wire logic        monitor_fine_trap_enable,
    input wire logic        nested_virt_enable,
    input wire logic        nested_virt_memory_redirect,
    input wire logic        halted,
    input wire logic        secure_debug_disabled,
    // register access
    input wire logic        acc_valid,
    input wire logic        acc_write,
    input wire logic [1:0]  acc_op0,
    input wire logic [2:0]  acc_op1,
    input wire logic [3:0]  acc_crn,
    input wire logic [3:0]  acc_crm,
    input wire logic [2:0]  acc_op2,
    input wire logic [63:0] acc_wdata,
    input wire logic        acc_undef,
    input wire logic        acc_trap_hyp,
    input wire logic        acc_trap_mon,
    input wire logic        acc_redirect,
    input wire logic [11:0] acc_redirect_offset,
    // guest checks
    input wire logic        chk_valid,
    input wire logic        chk_write,
    input wire logic [2:0]  chk_target,
    input wire logic        chk_higher_exc,
    input wire logic        chk_trap,
    input wire logic [5:0]  chk_syndrome,
    // register contents
    input wire logic [63:0] read_trap_value,
    input wire logic [63:0] write_trap_value
);
    timeunit 1ns;
    timeprecision 1ps;
    wire logic enc = acc_op0 == `ENC_OP0 && acc_op1 == `ENC_OP1 && acc_crn == `ENC_CRN
                     && acc_crm == `ENC_CRM;
    wire logic rd_hit = acc_valid && enc && acc_op2 == `ENC_OP2_RD;
    wire logic wr_hit = acc_valid && enc && acc_op2 == `ENC_OP2_WR;
    wire logic mon_gate = monitor_present && !monitor_fine_trap_enable;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    property p_reset_clear; $rose(rst_b) |-> read_trap_value == 64'h0 && write_trap_value == 64'h0;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("registers not clear");
    property p_rd_trap; chk_valid && !chk_write && chk_target == `TGT_AUXF && cur_el == `EL1
        && read_trap_value[0] && hyp_enabled && !mon_gate && !chk_higher_exc
        |=> chk_trap && chk_syndrome == 6'h18; endproperty
    a_rd_trap: assert property (p_rd_trap) else $error("read trap missing");
    property p_user_undef; (rd_hit || wr_hit) && cur_el == `EL0 |=> acc_undef; endproperty
    a_user_undef: assert property (p_user_undef) else $error("user access not undefined");
    property p_redirect; rd_hit && cur_el == `EL1 && hyp_enabled && nested_virt_enable
        && nested_virt_memory_redirect |=> acc_redirect && acc_redirect_offset == 12'h1B8;
    endproperty
    a_redirect: assert property (p_redirect) else $error("redirect wrong");
    property p_nv_trap; rd_hit && cur_el == `EL1 && hyp_enabled && nested_virt_enable
        && !nested_virt_memory_redirect |=> acc_trap_hyp && !acc_undef; endproperty
    a_nv_trap: assert property (p_nv_trap) else $error("nested trap missing");
    property p_mon_trap; rd_hit && cur_el == `EL2 && mon_gate
        && !(halted && secure_debug_disabled) |=> acc_trap_mon; endproperty
    a_mon_trap: assert property (p_mon_trap) else $error("monitor trap missing");
    property p_halt_undef; rd_hit && cur_el == `EL2 && mon_gate && halted
        && secure_debug_disabled |=> acc_undef && !acc_trap_mon; endproperty
    a_halt_undef: assert property (p_halt_undef) else $error("halted access not undefined");
    property p_direct; rd_hit && acc_write && cur_el == `EL3
        |=> read_trap_value == $past(acc_wdata); endproperty
    a_direct: assert property (p_direct) else $error("direct write lost");
    property p_no_fgt; wr_hit && !fine_grained_trap_feature |=> acc_undef; endproperty
    a_no_fgt: assert property (p_no_fgt) else $error("absent register not undefined");
    property p_higher; chk_valid && chk_higher_exc |=> !chk_trap; endproperty
    a_higher: assert property (p_higher) else $error("trap over higher exception");
endmodule
bind fine_grained_sysreg_trap_control fgt_trap_checker i_fgt_trap_checker (
    .sys_clk, .rst_b, .fine_grained_trap_feature, .monitor_present, .cur_el, .hyp_enabled,
    .monitor_fine_trap_enable, .nested_virt_enable, .nested_virt_memory_redirect, .halted,
    .secure_debug_disabled, .acc_valid, .acc_write, .acc_op0, .acc_op1, .acc_crn, .acc_crm,
    .acc_op2, .acc_wdata, .acc_undef, .acc_trap_hyp, .acc_trap_mon, .acc_redirect,
    .acc_redirect_offset, .chk_valid, .chk_write, .chk_target, .chk_higher_exc, .chk_trap,
    .chk_syndrome, .read_trap_value, .write_trap_value
);
`default_nettype wire

// ---- fine_grained_sysreg_trap_control_tb.sv ----
/* self-checking bench for the trap control block.
   assumes the defines header on the include path and the checker bound. */
`default_nettype none
`include "fgt_defines.vh"
module fine_grained_sysreg_trap_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [63:0] ones = 64'hFFFF_FFFF_FFFF_FFFF;
    localparam logic [4:0]  st_dir = 5'h10, st_und = 5'h18, st_hyp = 5'h14, st_mon = 5'h12;
    localparam logic [4:0]  st_red = 5'h11;
    localparam logic [2:0]  rd_op = `ENC_OP2_RD, wr_op = `ENC_OP2_WR;
    logic        sys_clk, rst_b, fine_grained_trap_feature, feat_mtx, feat_accdata, feat_ras, feat_rasv1p1;
    logic        ras_records_absent, monitor_present, sdd_undef_first, hyp_enabled, halted;
    logic        monitor_fine_trap_enable, nested_virt_enable, nested_virt_memory_redirect;
    logic        host_kernel_at_hyp, trap_general_to_hyp, secure_debug_disabled, chk_trap;
    logic        acc_valid, acc_write, chk_valid, chk_write, chk_higher_exc, acc_done;
    logic        acc_undef, acc_trap_hyp, acc_trap_mon, acc_redirect;
    logic [1:0]  cur_el, acc_op0;
    logic [2:0]  acc_op1, acc_op2, chk_target;
    logic [3:0]  acc_crn, acc_crm;
    logic [5:0]  chk_syndrome;
    logic [11:0] acc_redirect_offset;
    logic [63:0] acc_wdata, acc_rdata, read_trap_value, write_trap_value, rd;
    int          miscompares = 0;
    int          tests_run = 0;

    fine_grained_sysreg_trap_control i_fine_grained_sysreg_trap_control (
        .sys_clk, .rst_b, .fine_grained_trap_feature, .feat_mtx, .feat_accdata, .feat_ras, .feat_rasv1p1,
        .ras_records_absent, .monitor_present, .sdd_undef_first, .cur_el, .hyp_enabled,
        .monitor_fine_trap_enable, .nested_virt_enable, .nested_virt_memory_redirect,
        .host_kernel_at_hyp, .trap_general_to_hyp, .halted, .secure_debug_disabled,
        .acc_valid, .acc_write, .acc_op0, .acc_op1, .acc_crn, .acc_crm, .acc_op2, .acc_wdata,
        .acc_rdata, .acc_done, .acc_undef, .acc_trap_hyp, .acc_trap_mon, .acc_redirect,
        .acc_redirect_offset, .chk_valid, .chk_write, .chk_target, .chk_higher_exc,
        .chk_trap, .chk_syndrome, .read_trap_value, .write_trap_value
    );

    always #5 sys_clk = ~sys_clk;

    task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
        begin
            tests_run++;
            if (got !== exp)
            begin
                miscompares++;
                $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask

    task automatic conclude;
        begin
            if (miscompares == 0 && tests_run > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask

    // straps except sdd_undef_first only move while reset is held
    task automatic rst(input logic [6:0] s);
        begin
            @(posedge sys_clk);
            rst_b <= 1'b0;
            {monitor_present, feat_mtx, ras_records_absent, fine_grained_trap_feature, feat_accdata, feat_ras,
             feat_rasv1p1} <= s;
            repeat (2) @(posedge sys_clk);
            rst_b <= 1'b1;
            @(posedge sys_clk);
            #1;
            cmp(read_trap_value, 64'h0);
            cmp(write_trap_value, 64'h0);
        end
    endtask

    task automatic set_state(input logic [8:0] v);
        begin
            @(posedge sys_clk);
            {hyp_enabled, nested_virt_enable, nested_virt_memory_redirect,
             monitor_fine_trap_enable, halted, secure_debug_disabled, sdd_undef_first,
             host_kernel_at_hyp, trap_general_to_hyp} <= v;
        end
    endtask

    // one request, answer sampled one cycle later; status is done,undef,hyp,mon,redirect
    task automatic acc(input logic [1:0] el, input logic w, input logic [2:0] op2,
                       input logic [63:0] d, input logic [4:0] st);
        begin
            @(posedge sys_clk);
            {cur_el, acc_valid, acc_write, acc_op2, acc_wdata} <= {el, 1'b1, w, op2, d};
            @(posedge sys_clk);
            acc_valid <= 1'b0;
            #1;
            cmp({59'h0, acc_done, acc_undef, acc_trap_hyp, acc_trap_mon, acc_redirect},
                {59'h0, st});
            rd = acc_rdata;
        end
    endtask

    task automatic chk(input logic [1:0] el, input logic w, input logic [2:0] t,
                       input logic h, input logic e);
        begin
            @(posedge sys_clk);
            {cur_el, chk_valid, chk_write, chk_target, chk_higher_exc} <= {el, 1'b1, w, t, h};
            @(posedge sys_clk);
            chk_valid <= 1'b0;
            #1;
            cmp({57'h0, chk_trap, chk_syndrome}, e ? 64'h0000_0000_0000_0058 : 64'h0);
        end
    endtask

    task automatic t_direct;
        begin
            rst(7'h2F);
            acc(`EL3, 1'b1, rd_op, ones, st_dir);
            acc(`EL3, 1'b1, 3'h6, 64'h0, 5'h00);
            acc(`EL3, 1'b0, rd_op, 64'h0, st_dir);
            cmp(rd, ones);
            acc(`EL3, 1'b1, wr_op, ones, st_dir);
            cmp(write_trap_value, 64'h00C7_BFFF_FFFF_FFFF);
        end
    endtask

    task automatic t_levels;
        begin
            acc(`EL0, 1'b1, rd_op, 64'h0, st_und);
            cmp(read_trap_value, ones);
            set_state(9'h1C0);
            acc(`EL1, 1'b0, rd_op, 64'h0, st_red);
            cmp({52'h0, acc_redirect_offset}, 64'h0000_0000_0000_01B8);
            set_state(9'h180);
            acc(`EL1, 1'b1, rd_op, 64'h0, st_hyp);
            set_state(9'h100);
            acc(`EL1, 1'b1, rd_op, 64'h0, st_und);
            cmp(read_trap_value, ones);
        end
    endtask

    // inverted fields trap when clear, the others when set
    task automatic t_checks;
        int i;
        begin
            chk(`EL1, 1'b0, `TGT_AUXF, 1'b0, 1'b1);
            for (i = 0; i < 8; i++)
                chk(`EL1, 1'b1, i[2:0], 1'b0, !(i inside {2, 3, 4}));
            chk(`EL1, 1'b1, `TGT_EADDR, 1'b1, 1'b0);
            acc(`EL3, 1'b1, wr_op, 64'h0, st_dir);
            acc(`EL3, 1'b1, rd_op, 64'h0, st_dir);
            chk(`EL1, 1'b0, `TGT_AUXF, 1'b0, 1'b0);
            for (i = 0; i < 8; i++)
                chk(`EL1, 1'b1, i[2:0], 1'b0, i inside {2, 3, 4});
            chk(`EL0, 1'b1, `TGT_TID2, 1'b0, 1'b1);
            set_state(9'h103);
            chk(`EL1, 1'b1, `TGT_TID2, 1'b0, 1'b0);
        end
    endtask

    task automatic t_monitor;
        begin
            rst(7'h6F);
            set_state(9'h100);
            acc(`EL2, 1'b1, rd_op, ones, st_mon);
            cmp(read_trap_value, 64'h0);
            set_state(9'h118);
            acc(`EL2, 1'b0, rd_op, 64'h0, st_und);
            set_state(9'h11C);
            acc(`EL2, 1'b0, rd_op, 64'h0, st_und);
            set_state(9'h120);
            acc(`EL2, 1'b1, rd_op, 64'h1234_5678_9ABC_DEF0, st_dir);
            acc(`EL2, 1'b0, rd_op, 64'h0, st_dir);
            cmp(rd, 64'h1234_5678_9ABC_DEF0);
        end
    endtask

    task automatic t_features;
        begin
            rst(7'h13);
            acc(`EL3, 1'b1, wr_op, ones, st_und);
            cmp(write_trap_value, 64'h0);
            rst(7'h1B);
            acc(`EL3, 1'b1, wr_op, ones, st_dir);
            cmp(write_trap_value, 64'h0000_0FFF_FFFF_FFFF);
            chk(`EL1, 1'b1, `TGT_TID2, 1'b0, 1'b0);
        end
    endtask

    initial
    begin
        {sys_clk, rst_b, fine_grained_trap_feature, feat_mtx, feat_accdata, feat_ras, feat_rasv1p1,
         ras_records_absent, monitor_present, sdd_undef_first, hyp_enabled, halted,
         monitor_fine_trap_enable, nested_virt_enable, nested_virt_memory_redirect,
         host_kernel_at_hyp, trap_general_to_hyp, secure_debug_disabled, acc_valid,
         acc_write, chk_valid, chk_write, chk_higher_exc, cur_el, acc_op2, chk_target,
         acc_wdata} = '0;
        {acc_op0, acc_op1, acc_crn, acc_crm} = {`ENC_OP0, `ENC_OP1, `ENC_CRN, `ENC_CRM};
        t_direct;
        t_levels;
        t_checks;
        t_monitor;
        t_features;
        conclude;
    end

    initial
    begin
        #200000;
        miscompares++;
        conclude;
    end
endmodule
`default_nettype wire
